// ---- asr_defines.svh ----
// Purpose: Constants of the analog scan and readout-on-change block.
// Assumes: Included by asr_evt_tmr, asr_scan and the bench.
// Notes:   Field ranges are written as macros for part-selects.
//
// Overview of operation
// - Remote request with type 255, timer zero starts one scan of all channels.
// - Remote request acted on only when it addresses this node.
// - Type 255, nonzero timer: scan every period seconds; remote requests too.
// - Timer expiry during a running forced scan is discarded.
// - Optional calibration before every scan.
// - Delta and window reporting have independent enables.
// - Global enable plus a mode runs a continuous loop when operational.
// - Change reports use microvolts; counts only without valid calibration.
// - A channel hitting both conditions sends one message per cycle.
// - Delta report when reading moves by threshold; reading becomes reference.
// - References load from the first change scan after entering operational.
// - Sync or remote request aborts change scan and forces full readout.
// - Timer forces full readout; forced scans leave references alone.
// - Per-channel delta threshold, zero disables, subindex 255 loads all.
// - Window report when reading leaves lower or upper limit.
// - Outside report only after configured consecutive outside readings.
// - Return inside reported at once, only if outside was reported.
// - Consecutive means successive scan cycles of the same channel.
// - Microvolt message: channel, status, 32-bit value LSB first, 6 bytes.
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define ASR_A_CFG   8'h00
`define ASR_A_TXT   8'h04
`define ASR_A_EVT   8'h08
`define ASR_A_NODE  8'h0C
`define ASR_A_SEL   8'h10
`define ASR_A_DLT   8'h14
`define ASR_A_UPR   8'h18
`define ASR_A_LWR   8'h1C
`define ASR_A_STAT  8'h20

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ASR_F_NCH   6:0
`define ASR_F_CAL   7
`define ASR_F_DEN   8
`define ASR_F_WEN   9
`define ASR_F_GLB   10
`define ASR_F_CALV  11
`define ASR_F_ADCF  18:12
`define ASR_F_EXC   26:19
`define ASR_F_TT2   7:0
`define ASR_F_TT3   15:8
`define ASR_F_EVT   15:0
`define ASR_F_NODE  6:0
`define ASR_CFG_RST 32'h0000_0000
`define ASR_TXT_RST 32'h0000_FFFF

// ----------------------------------------
// Protocol codes and timing
// ----------------------------------------
`define ASR_TT_EVT  8'hFF
`define ASR_TT_SYNC 8'h01
`define ASR_COB_CNT 11'h280
`define ASR_COB_UV  11'h380
`define ASR_SUB_ALL 8'hFF
`define ASR_NCH_MAX 64
`define ASR_LEN_UV  3'h6
`define ASR_LEN_CNT 3'h4
`define ASR_EVT_UNIT_S 1
`define ASR_CLK_HZ  200000000

`endif

// ---- asr_pkg.sv ----
// Purpose: Types shared by the scan block.
// Assumes: Nothing.
// Notes:   States follow a Gray path idle-cal-conv-eval-send.
package asr_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CAL  = 3'h1,
		ST_CONV = 3'h3,
		ST_EVAL = 3'h2,
		ST_SEND = 3'h6
	} asr_state_t;

	typedef struct packed {
		logic               done;
		logic               err;
		logic [15:0]        cnt;
		logic signed [31:0] uv;
	} asr_adc_t;

	typedef struct packed {
		logic        uv;
		logic [2:0]  len;
		logic [7:0]  chan;
		logic [7:0]  stat;
		logic [31:0] val;
	} asr_msg_t;
endpackage : asr_pkg

// ---- asr_evt_tmr.sv ----
// Purpose: Event timer counting whole seconds, one pulse per period.
// Assumes: Period in seconds; run low holds the timer cleared.
// Notes:   TICK_CYC may be shortened for simulation.
`timescale 1ns/1ps
`include "asr_defines.svh"
module asr_evt_tmr import asr_pkg::*; #(
	parameter int TICK_CYC = `ASR_EVT_UNIT_S * `ASR_CLK_HZ
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        run,
	input  wire logic [15:0] period,
	output logic             expire
);
	logic [27:0] pre_r;
	logic [15:0] sec_r;

	always_ff @(posedge core_clk) begin
		if (!rstn || !run) begin
			pre_r  <= 28'h0000000;
			sec_r  <= 16'h0000;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (pre_r == 28'(TICK_CYC - 1)) begin
				pre_r <= 28'h0000000;
				if (sec_r + 16'h0001 >= period) begin
					sec_r  <= 16'h0000;
					expire <= 1'b1;
				end else begin
					sec_r <= sec_r + 16'h0001;
				end
			end else begin
				pre_r <= pre_r + 28'h0000001;
			end
		end
	end
endmodule : asr_evt_tmr

// ---- asr_judge.sv ----
// Purpose: Decides whether one change-scan reading is reported.
// Assumes: Reading and limits in microvolts, signed.
// Notes:   Pure combinational; caller stores the new channel state.
`timescale 1ns/1ps
module asr_judge import asr_pkg::*; (
	input  wire logic signed [31:0] rd,
	input  wire logic signed [31:0] ref_v,
	input  wire logic [31:0]        thr,
	input  wire logic signed [31:0] upr,
	input  wire logic signed [31:0] lwr,
	input  wire logic [7:0]         cnt,
	input  wire logic               rep,
	input  wire logic [7:0]         exc,
	input  wire logic               den,
	input  wire logic               wen,
	input  wire logic               first,
	output logic                    send,
	output logic                    ref_ld,
	output logic [7:0]              cnt_nxt,
	output logic                    rep_nxt
);
	logic signed [32:0] diff;
	logic [32:0]        mag;
	logic               dhit;
	logic               outside;
	logic               wout;
	logic               wback;

	always_comb begin
		diff    = 33'(rd) - 33'(ref_v);
		mag     = diff[32] ? 33'(-diff) : 33'(diff);
		// Zero threshold switches the check off
		dhit    = den && !first && thr != 32'h0 && mag >= {1'b0, thr};
		ref_ld  = first || dhit;
		outside = rd < lwr || rd > upr;
		cnt_nxt = 8'h00;
		rep_nxt = 1'b0;
		wout    = 1'b0;
		wback   = 1'b0;
		if (wen && outside) begin
			cnt_nxt = (cnt == 8'hFF) ? cnt : cnt + 8'h01;
			wout    = !rep && cnt_nxt >= exc;
			rep_nxt = rep || wout;
		end else if (wen) begin
			wback = rep;
		end
		send = dhit || wout || wback;
	end
endmodule : asr_judge

// ---- asr_scan.sv ----
// Purpose: Analog scan controller with forced and on-change readout.
// Assumes: APB slave; ADC and calibration engines answer by pulses.
// Notes:   An abort is taken at a channel boundary, never mid-conversion.
`timescale 1ns/1ps
`include "asr_defines.svh"
module asr_scan import asr_pkg::*; #(
	parameter int TICK_CYC = `ASR_EVT_UNIT_S * `ASR_CLK_HZ
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        nmt_oper,
	input  wire logic        rtr_valid,
	input  wire logic [10:0] rtr_cobid,
	input  wire logic        sync_pulse,
	input  wire asr_adc_t    adc_rsp,
	input  wire logic        cal_done,
	output logic             adc_req,
	output logic [5:0]       adc_chan,
	output logic             cal_req,
	output logic             msg_valid,
	output asr_msg_t         msg
);
	// ----------------------------------------
	// Registers and channel memories
	// ----------------------------------------
	logic [31:0]        cfg_r;
	logic [31:0]        txt_r;
	logic [31:0]        evt_r;
	logic [31:0]        node_r;
	logic [7:0]         sel_r;
	logic [31:0]        thr_m [`ASR_NCH_MAX];
	logic signed [31:0] upr_m [`ASR_NCH_MAX];
	logic signed [31:0] lwr_m [`ASR_NCH_MAX];
	logic signed [31:0] ref_m [`ASR_NCH_MAX];
	logic [7:0]         cnt_m [`ASR_NCH_MAX];
	logic               rep_m [`ASR_NCH_MAX];

	asr_state_t state_r;
	logic [5:0] chan_r;
	logic       forced_r;
	logic       uv_r;
	logic       pend_r;
	logic       pend_uv_r;
	logic       first_r;
	logic       op_q;
	asr_adc_t   rd_r;
	logic [31:0] rd_mux;
	logic        hit;
	logic        wr;

	// ----------------------------------------
	// APB slave, one wait-free access phase
	// ----------------------------------------
	assign wr = psel && penable && pready && pwrite;

	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			`ASR_A_CFG:  rd_mux = cfg_r;
			`ASR_A_TXT:  rd_mux = txt_r;
			`ASR_A_EVT:  rd_mux = evt_r;
			`ASR_A_NODE: rd_mux = node_r;
			`ASR_A_SEL:  rd_mux = {24'h000000, sel_r};
			`ASR_A_DLT:  rd_mux = thr_m[sel_r[5:0]];
			`ASR_A_UPR:  rd_mux = upr_m[sel_r[5:0]];
			`ASR_A_LWR:  rd_mux = lwr_m[sel_r[5:0]];
			`ASR_A_STAT: rd_mux = {20'h00000, forced_r, first_r, pend_r,
			                       state_r, chan_r};
			default:     hit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable && !pready;
			if (psel && !penable) begin
				prdata  <= rd_mux;
				pslverr <= !hit;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cfg_r  <= `ASR_CFG_RST;
			txt_r  <= `ASR_TXT_RST;
			evt_r  <= 32'h0000_0000;
			node_r <= 32'h0000_0000;
			sel_r  <= 8'h00;
		end else if (wr) begin
			case (paddr)
				`ASR_A_CFG:  cfg_r  <= pwdata;
				`ASR_A_TXT:  txt_r  <= pwdata;
				`ASR_A_EVT:  evt_r  <= pwdata;
				`ASR_A_NODE: node_r <= pwdata;
				`ASR_A_SEL:  sel_r  <= pwdata[7:0];
				default:     ;
			endcase
		end
	end

	// Limits and thresholds may change while scanning
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			for (int i = 0; i < `ASR_NCH_MAX; i++) begin
				thr_m[i] <= 32'h0000_0000;
				upr_m[i] <= 32'h0000_0000;
				lwr_m[i] <= 32'h0000_0000;
			end
		end else if (wr) begin
			for (int i = 0; i < `ASR_NCH_MAX; i++) begin
				if (sel_r == `ASR_SUB_ALL || sel_r == 8'(i)) begin
					case (paddr)
						`ASR_A_DLT: thr_m[i] <= pwdata;
						`ASR_A_UPR: upr_m[i] <= pwdata;
						`ASR_A_LWR: lwr_m[i] <= pwdata;
						default:    ;
					endcase
				end
			end
		end
	end

	// ----------------------------------------
	// Triggers
	// ----------------------------------------
	logic [7:0] tt2;
	logic [7:0] tt3;
	logic [6:0] nch;
	logic       calv;
	logic       rtr_cnt;
	logic       rtr_uv;
	logic       rtr_go;
	logic       sync_go;
	logic       tmr_run;
	logic       tmr_exp;
	logic       tmr_go;
	logic       loop_on;
	logic       last;

	always_comb begin
		tt2  = txt_r[`ASR_F_TT2];
		tt3  = txt_r[`ASR_F_TT3];
		nch  = cfg_r[`ASR_F_NCH];
		calv = cfg_r[`ASR_F_CALV];
		rtr_cnt = rtr_valid && rtr_cobid ==
		          `ASR_COB_CNT + 11'(node_r[`ASR_F_NODE]);
		rtr_uv  = rtr_valid && rtr_cobid ==
		          `ASR_COB_UV + 11'(node_r[`ASR_F_NODE]);
		rtr_go  = nmt_oper && ((rtr_cnt && tt2 == `ASR_TT_EVT) ||
		          (rtr_uv && tt3 == `ASR_TT_EVT));
		sync_go = nmt_oper && sync_pulse &&
		          (tt2 == `ASR_TT_SYNC || tt3 == `ASR_TT_SYNC);
		tmr_run = nmt_oper && evt_r[`ASR_F_EVT] != 16'h0000 &&
		          (tt2 == `ASR_TT_EVT || tt3 == `ASR_TT_EVT);
		// Busy forced scan swallows the expiry
		tmr_go  = tmr_exp && !pend_r &&
		          !(forced_r && state_r != ST_IDLE);
		loop_on = nmt_oper && cfg_r[`ASR_F_GLB] &&
		          (cfg_r[`ASR_F_DEN] || cfg_r[`ASR_F_WEN]);
		last    = 7'(chan_r) == nch - 7'h01;
	end

	asr_evt_tmr #(.TICK_CYC(TICK_CYC)) u_tmr (
		.core_clk (core_clk),
		.rstn     (rstn),
		.run      (tmr_run),
		.period   (evt_r[`ASR_F_EVT]),
		.expire   (tmr_exp)
	);

	// A new request wins over the clear of the start
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pend_r    <= 1'b0;
			pend_uv_r <= 1'b0;
		end else if (rtr_go || sync_go || tmr_go) begin
			pend_r    <= 1'b1;
			if (rtr_go)
				pend_uv_r <= rtr_uv;
			else if (sync_go)
				pend_uv_r <= tt3 == `ASR_TT_SYNC && calv;
			else
				pend_uv_r <= tt3 == `ASR_TT_EVT && calv;
		end else if (state_r == ST_IDLE && nch != 7'h00) begin
			pend_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Change judgement
	// ----------------------------------------
	logic       j_send;
	logic       j_ref;
	logic [7:0] j_cnt;
	logic       j_rep;

	asr_judge u_judge (
		.rd      (rd_r.uv),
		.ref_v   (ref_m[chan_r]),
		.thr     (thr_m[chan_r]),
		.upr     (upr_m[chan_r]),
		.lwr     (lwr_m[chan_r]),
		.cnt     (cnt_m[chan_r]),
		.rep     (rep_m[chan_r]),
		.exc     (cfg_r[`ASR_F_EXC]),
		.den     (cfg_r[`ASR_F_DEN]),
		.wen     (cfg_r[`ASR_F_WEN]),
		.first   (first_r),
		.send    (j_send),
		.ref_ld  (j_ref),
		.cnt_nxt (j_cnt),
		.rep_nxt (j_rep)
	);

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			for (int i = 0; i < `ASR_NCH_MAX; i++) begin
				ref_m[i] <= 32'h0000_0000;
				cnt_m[i] <= 8'h00;
				rep_m[i] <= 1'b0;
			end
		end else if (state_r == ST_EVAL && !forced_r) begin
			if (j_ref)
				ref_m[chan_r] <= rd_r.uv;
			cnt_m[chan_r] <= j_cnt;
			rep_m[chan_r] <= j_rep;
		end
	end

	// First full change cycle seeds the references
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			op_q    <= 1'b0;
			first_r <= 1'b0;
		end else begin
			op_q <= nmt_oper;
			if (nmt_oper && !op_q)
				first_r <= 1'b1;
			else if (!forced_r && last && !pend_r &&
			         (state_r == ST_SEND ||
			          (state_r == ST_EVAL && !j_send)))
				first_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Scan sequencer
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_r   <= ST_IDLE;
			chan_r    <= 6'h00;
			forced_r  <= 1'b0;
			uv_r      <= 1'b0;
			rd_r      <= '0;
			adc_req   <= 1'b0;
			adc_chan  <= 6'h00;
			cal_req   <= 1'b0;
			msg_valid <= 1'b0;
			msg       <= '0;
		end else begin
			adc_req   <= 1'b0;
			cal_req   <= 1'b0;
			msg_valid <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (nch != 7'h00 && (pend_r || loop_on)) begin
						forced_r <= pend_r;
						uv_r     <= pend_r ? pend_uv_r : calv;
						chan_r   <= 6'h00;
						adc_chan <= 6'h00;
						if (cfg_r[`ASR_F_CAL]) begin
							cal_req <= 1'b1;
							state_r <= ST_CAL;
						end else begin
							adc_req <= 1'b1;
							state_r <= ST_CONV;
						end
					end
				end
				ST_CAL: begin
					if (cal_done) begin
						adc_req <= 1'b1;
						state_r <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (adc_rsp.done) begin
						rd_r    <= adc_rsp;
						state_r <= ST_EVAL;
					end
				end
				ST_EVAL: begin
					msg.uv   <= uv_r;
					msg.len  <= uv_r ? `ASR_LEN_UV : `ASR_LEN_CNT;
					msg.chan <= {2'b00, chan_r};
					msg.stat <= {rd_r.err, cfg_r[`ASR_F_ADCF]};
					msg.val  <= uv_r ? rd_r.uv : {16'h0000, rd_r.cnt};
					if (forced_r || j_send) begin
						state_r <= ST_SEND;
					end else if (pend_r || last) begin
						state_r <= ST_IDLE;
					end else begin
						chan_r   <= chan_r + 6'h01;
						adc_chan <= chan_r + 6'h01;
						adc_req  <= 1'b1;
						state_r  <= ST_CONV;
					end
				end
				ST_SEND: begin
					msg_valid <= 1'b1;
					if (pend_r || last) begin
						state_r <= ST_IDLE;
					end else begin
						chan_r   <= chan_r + 6'h01;
						adc_chan <= chan_r + 6'h01;
						adc_req  <= 1'b1;
						state_r  <= ST_CONV;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence s_start;
		state_r == ST_IDLE ##1 state_r != ST_IDLE;
	endsequence

	sequence s_send;
		state_r == ST_SEND ##1 msg_valid;
	endsequence

	chk_rtr_foreign: assert property (
		rtr_valid && rtr_cobid[`ASR_F_NODE] != node_r[`ASR_F_NODE] &&
		!sync_go && !tmr_go && !pend_r |=> !pend_r)
		else $error("foreign remote request was taken");

	chk_rtr_start: assert property (
		state_r == ST_IDLE && !pend_r && rtr_go && nch != 7'h00 &&
		!loop_on |-> ##2 forced_r && state_r != ST_IDLE)
		else $error("remote request did not start a forced scan");

	chk_tmr_drop: assert property (
		tmr_exp && forced_r && state_r != ST_IDLE && !pend_r &&
		!rtr_go && !sync_go |=> !pend_r)
		else $error("timer expiry during forced scan was kept");

	chk_cal_first: assert property (
		s_start |-> state_r == (cfg_r[`ASR_F_CAL] ? ST_CAL : ST_CONV))
		else $error("calibration step wrong at scan start");

	chk_one_msg: assert property (
		s_send |=> !msg_valid)
		else $error("more than one message for a channel");

	chk_forced_ref: assert property (
		state_r == ST_EVAL && forced_r |=> ref_m[$past(chan_r)] ==
		$past(ref_m[chan_r]))
		else $error("forced scan changed a reference");

	chk_msg_len: assert property (
		msg_valid |-> msg.len == (msg.uv ? `ASR_LEN_UV : `ASR_LEN_CNT))
		else $error("message length does not match its kind");

	chk_scan_order: assert property (
		$changed(chan_r) |-> chan_r == 6'h00 ||
		chan_r == $past(chan_r) + 6'h01)
		else $error("channel order broken");
endmodule : asr_scan

// ---- asr_adc_model.sv ----
// Purpose: Behavioural ADC and calibration engine beside the scan block.
// Assumes: Requests are one-cycle pulses; reading comes from the bench.
// Notes:   Data bus shows inverted reading outside the done cycle.
`timescale 1ns/1ps
module asr_adc_model import asr_pkg::*; #(
	parameter int DLY     = 4,
	parameter int CAL_DLY = 9
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        adc_req,
	input  wire logic        cal_req,
	input  wire logic [5:0]  adc_chan,
	input  wire logic [31:0] uv_in,
	output asr_adc_t         adc_rsp,
	output logic             cal_done
);
	logic [3:0] acnt_r;
	logic [3:0] ccnt_r;
	logic [5:0] ch_r;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			acnt_r <= 4'h0;
			ccnt_r <= 4'h0;
			ch_r   <= 6'h00;
		end else begin
			if (adc_req) begin
				acnt_r <= 4'(DLY);
				ch_r   <= adc_chan;
			end else if (acnt_r != 4'h0)
				acnt_r <= acnt_r - 4'h1;
			if (cal_req)
				ccnt_r <= 4'(CAL_DLY);
			else if (ccnt_r != 4'h0)
				ccnt_r <= ccnt_r - 4'h1;
		end
	end

	// Stale data must not look valid, so it is inverted between answers
	always_comb begin
		adc_rsp.done = (acnt_r == 4'h1);
		adc_rsp.err  = 1'b0;
		// Channel offset makes the converted channel visible in the value
		adc_rsp.uv   = adc_rsp.done ? uv_in + 32'(ch_r) : ~uv_in;
		adc_rsp.cnt  = adc_rsp.uv[15:0];
	end
	assign cal_done = (ccnt_r == 4'h1);
endmodule : asr_adc_model

// ---- asr_scan_tb.sv ----
// Purpose: Self-checking bench of the scan controller.
// Assumes: Zero-wait APB slave; timer tick shortened to 200 cycles.
// Notes:   Message fields are checked from a captured queue.
`timescale 1ns/1ps
`include "asr_defines.svh"
module asr_scan_tb import asr_pkg::*;;
	logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, uv_in, rd;
	logic        nmt_oper, rtr_valid, sync_pulse, cal_done, adc_req, cal_req;
	logic        msg_valid, er;
	logic [10:0] rtr_cobid;
	logic [5:0]  adc_chan;
	asr_adc_t    adc_rsp;
	asr_msg_t    msg;
	asr_msg_t    q[$];
	int          n_mismatch, checked, ncal;

	asr_scan #(.TICK_CYC(200)) dut (.core_clk(core_clk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nmt_oper(nmt_oper), .rtr_valid(rtr_valid),
		.rtr_cobid(rtr_cobid), .sync_pulse(sync_pulse), .adc_rsp(adc_rsp),
		.cal_done(cal_done), .adc_req(adc_req), .adc_chan(adc_chan),
		.cal_req(cal_req), .msg_valid(msg_valid), .msg(msg));
	asr_adc_model adc (.core_clk(core_clk), .rstn(rstn), .adc_req(adc_req),
		.cal_req(cal_req), .adc_chan(adc_chan), .uv_in(uv_in),
		.adc_rsp(adc_rsp),
		.cal_done(cal_done));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (msg_valid === 1'b1)
			q.push_back(msg);
		if (cal_req === 1'b1)
			ncal++;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task end_sim;
		if (n_mismatch == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task tmo;
		n_mismatch++;
		end_sim;
	endtask : tmo

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1)
			tmo;
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task trig(input logic s, input logic [10:0] id);
		@(posedge core_clk);
		sync_pulse <= s;
		rtr_valid  <= ~s;
		rtr_cobid  <= id;
		@(posedge core_clk);
		sync_pulse <= 1'b0;
		rtr_valid  <= 1'b0;
	endtask : trig

	task wait_msgs(input int n);
		int j;
		for (j = 0; j < 3000 && q.size() < n; j++)
			@(posedge core_clk);
		if (q.size() < n)
			tmo;
	endtask : wait_msgs

	task wait_dones(input int n);
		int j;
		for (int k = 0; k < n; k++) begin
			j = 0;
			do begin
				@(posedge core_clk);
				j++;
			end while (adc_rsp.done !== 1'b1 && j < 500);
			if (adc_rsp.done !== 1'b1)
				tmo;
		end
	endtask : wait_dones

	task chk_msg(input int i, input logic [7:0] ch, input logic u,
			input logic [31:0] v);
		chk({31'h0, q[i].uv}, {31'h0, u});
		chk({29'h0, q[i].len}, {29'h0, u ? `ASR_LEN_UV : `ASR_LEN_CNT});
		chk({24'h0, q[i].chan}, {24'h0, ch});
		chk({24'h0, q[i].stat}, 32'h0000_0015);
		chk(q[i].val, v);
	endtask : chk_msg

	task chk_scan(input logic u, input logic [31:0] v);
		wait_msgs(3);
		for (int i = 0; i < 3; i++)
			chk_msg(i, 8'(i), u, v + 32'(i));
		q.delete();
	endtask : chk_scan

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, rtr_valid, sync_pulse} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		rtr_cobid = 11'h000;
		uv_in = 32'h0000_1234;
		nmt_oper = 1'b1;
		rstn = 1'b0;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		apb(1'b0, `ASR_A_TXT, 32'h0);
		chk(rd, `ASR_TXT_RST);
		apb(1'b0, `ASR_A_CFG, 32'h0);
		chk(rd, `ASR_CFG_RST);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, `ASR_A_NODE, 32'h5);
		apb(1'b1, `ASR_A_TXT, 32'h0000_00FF);
		apb(1'b1, `ASR_A_CFG, 32'h0001_5803);
		trig(1'b0, 11'h286);
		repeat (200) @(posedge core_clk);
		chk(q.size(), 32'h0);
		trig(1'b0, 11'h285);
		chk_scan(1'b0, 32'h0000_1234);
		ncal = 0;
		apb(1'b1, `ASR_A_CFG, 32'h0001_5883);
		trig(1'b0, 11'h285);
		chk_scan(1'b0, 32'h0000_1234);
		chk(ncal, 32'h1);
		apb(1'b1, `ASR_A_CFG, 32'h0001_5803);
		apb(1'b1, `ASR_A_TXT, 32'h0000_FF00);
		trig(1'b0, 11'h385);
		chk_scan(1'b1, 32'h0000_1234);
		apb(1'b1, `ASR_A_TXT, 32'h0000_0100);
		trig(1'b1, 11'h080);
		chk_scan(1'b1, 32'h0000_1234);
		apb(1'b1, `ASR_A_TXT, 32'h0000_FF00);
		apb(1'b1, `ASR_A_EVT, 32'h1);
		repeat (1010) @(posedge core_clk);
		chk(q.size() >= 12 && q.size() <= 15, 32'h1);
		apb(1'b1, `ASR_A_EVT, 32'h0);
		repeat (100) @(posedge core_clk);
		q.delete();
		// Long scan of 40 channels: expiries inside it are dropped
		apb(1'b1, `ASR_A_CFG, 32'h0001_5828);
		apb(1'b1, `ASR_A_EVT, 32'h1);
		repeat (950) @(posedge core_clk);
		chk(q.size(), 32'h0000_0050);
		apb(1'b1, `ASR_A_EVT, 32'h0);
		repeat (100) @(posedge core_clk);
		q.delete();
		// Delta loop: references come from the first reading
		nmt_oper <= 1'b0;
		uv_in <= 32'd1000;
		apb(1'b1, `ASR_A_TXT, 32'h0);
		apb(1'b1, `ASR_A_CFG, 32'h0001_5D01);
		apb(1'b1, `ASR_A_SEL, 32'h0000_00FF);
		apb(1'b1, `ASR_A_DLT, 32'd100);
		apb(1'b0, `ASR_A_DLT, 32'h0);
		chk(rd, 32'h0000_0064);
		nmt_oper <= 1'b1;
		wait_dones(3);
		chk(q.size(), 32'h0);
		uv_in <= 32'd1100;
		wait_dones(2);
		chk(q.size(), 32'h1);
		chk_msg(0, 8'h0, 1'b1, 32'd1100);
		wait_dones(2);
		chk(q.size(), 32'h1);
		uv_in <= 32'd1000;
		wait_dones(2);
		chk(q.size(), 32'h2);
		q.delete();
		// Window loop with exceed count 2
		nmt_oper <= 1'b0;
		apb(1'b1, `ASR_A_CFG, 32'h0011_5E01);
		apb(1'b1, `ASR_A_UPR, 32'd2000);
		apb(1'b1, `ASR_A_LWR, 32'd0);
		nmt_oper <= 1'b1;
		wait_dones(3);
		chk(q.size(), 32'h0);
		uv_in <= 32'd3000;
		wait_dones(2);
		chk(q.size(), 32'h0);
		wait_dones(1);
		chk(q.size(), 32'h1);
		wait_dones(2);
		chk(q.size(), 32'h1);
		uv_in <= 32'd1000;
		wait_dones(2);
		chk(q.size(), 32'h2);
		chk_msg(1, 8'h0, 1'b1, 32'd1000);
		end_sim;
	end
endmodule : asr_scan_tb
